// *** hdl/dmc_device_end.sv ***
// Converter control end: selectors, gain, start, end of conversion, result ports
`timescale 1ns/1ps
module dmc_device_end (
  // Clock and reset
  input  wire  logic                          clk,
  input  wire  logic                          resetn,
  // Link to the host
  dmc_link_if.device                          link,
  // Analog front end, one lane per converter
  output logic [dmc_pkg::N_CONV-1:0][3:0]     feChannel,
  output logic [dmc_pkg::N_CONV-1:0][1:0]     feGain,
  output logic [dmc_pkg::N_CONV-1:0]          feHold,
  input  wire  dmc_pkg::dmc_sample_t          feSample [dmc_pkg::N_CONV]
);
  import dmc_pkg::*;

  // Selector and gain settings per converter
  logic [2:0]     chanCode_r [N_CONV];
  logic [1:0]     gain_r     [N_CONV];

  // Conversion state per converter
  logic [N_CONV-1:0] busy_r;
  logic [CNT_W-1:0]  cnt_r [N_CONV];
  logic [N_CONV-1:0] eoc_r;
  dmc_sample_t       sample_r [N_CONV];

  // Front end drive
  logic [N_CONV-1:0][3:0] feChannel_r;
  logic [N_CONV-1:0][1:0] feGain_r;
  logic [N_CONV-1:0]      feHold_r;

  // Wait for end of conversion
  logic              waitPend_r;
  logic [N_CONV-1:0] waitMask_r;
  logic              waitDone_r;
  logic              allDone;

  // Result read port
  logic              readValid_r;
  logic [WORD_W-1:0] readData_r;

  // Start decoding and conversion end
  logic [N_CONV-1:0] startHit;
  logic [N_CONV-1:0] convEnd;

  // Each selector takes its own control word; upper bits ignored
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < N_CONV; i++) begin
        chanCode_r[i] <= 3'h0;
        gain_r[i]     <= GAIN_X1;
      end
    end else begin
      for (int i = 0; i < N_CONV; i++) begin
        if (link.muxWrite[i]) begin // [R9]
          chanCode_r[i] <= link.cmdWord[CODE_MSB:CODE_LSB]; // [R8] [R10]
          gain_r[i]     <= link.cmdWord[GAIN_MSB:GAIN_LSB]; // [R7]
        end
      end
    end
  end

  // Channel number minus one on each selector; odd lane 0..14, even lane 1..15
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      feChannel_r <= '0;
    end else begin
      for (int i = 0; i < N_CONV; i++) begin
        feChannel_r[i] <= 4'(dmc_chan_of(chanCode_r[i], i[0]) - CH_MIN); // [R8] [R10]
      end
    end
  end

  // Start bit per converter; a busy converter ignores a new start
  always_comb begin
    for (int i = 0; i < N_CONV; i++) begin
      startHit[i] = link.startReq && link.cmdWord[i] && !busy_r[i]; // [R15] [R14]
    end
  end

  // Gain held steady for the whole conversion
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      feGain_r <= '0;
    end else begin
      for (int i = 0; i < N_CONV; i++) begin
        if (startHit[i]) begin
          feGain_r[i] <= gain_r[i]; // [R12]
        end
      end
    end
  end

  // Hold pulse tells the converter to sample its input
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      feHold_r <= '0;
    end else begin
      feHold_r <= startHit; // [R14]
    end
  end

  // Lane whose conversion finishes in this cycle
  always_comb begin
    for (int i = 0; i < N_CONV; i++) begin
      convEnd[i] = busy_r[i] && (cnt_r[i] == '0);
    end
  end

  // Conversion timer; runs for the fixed conversion time after a start
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      busy_r <= '0;
      for (int i = 0; i < N_CONV; i++) begin
        cnt_r[i] <= '0;
      end
    end else begin
      for (int i = 0; i < N_CONV; i++) begin
        if (startHit[i]) begin
          busy_r[i] <= 1'b1;
          cnt_r[i]  <= CNT_W'(CONV_CYCLES - 1); // [R16]
        end else if (convEnd[i]) begin
          busy_r[i] <= 1'b0;
        end else if (busy_r[i]) begin
          cnt_r[i] <= cnt_r[i] - 1'b1;
        end
      end
    end
  end

  // End of conversion; cleared by an accepted start, set as the lane finishes
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      eoc_r <= '0;
    end else begin
      for (int i = 0; i < N_CONV; i++) begin
        if (startHit[i]) begin
          eoc_r[i] <= 1'b0;
        end else if (convEnd[i]) begin
          eoc_r[i] <= 1'b1; // [R16]
        end
      end
    end
  end

  // Latest sample captured as the conversion ends
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < N_CONV; i++) begin
        sample_r[i] <= '0;
      end
    end else begin
      for (int i = 0; i < N_CONV; i++) begin
        if (convEnd[i]) begin
          sample_r[i] <= feSample[i]; // [R6] [R13]
        end
      end
    end
  end

  // All converters named in the wait pattern have finished
  assign allDone = ((eoc_r & waitMask_r) == waitMask_r); // [R18]

  // Wait operation; a new wait request restarts it
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      waitPend_r <= 1'b0;
      waitMask_r <= '0;
      waitDone_r <= 1'b0;
    end else begin
      waitDone_r <= 1'b0;
      if (waitPend_r && allDone) begin
        waitPend_r <= 1'b0;
        waitDone_r <= 1'b1; // [R18]
      end
      if (link.waitReq) begin
        waitPend_r <= 1'b1;
        waitMask_r <= link.cmdWord[N_CONV-1:0];
      end
    end
  end

  // Read answer strobe, one cycle after the request
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      readValid_r <= 1'b0;
    end else begin
      readValid_r <= link.readReq; // [R6]
    end
  end

  // Result word of the selected converter; held until the next read
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      readData_r <= '0;
    end else begin
      if (link.readReq) begin
        if (link.readWide) begin
          readData_r <= dmc_wide(sample_r[link.readSel]); // [R4] [R6]
        end else begin
          readData_r <= dmc_narrow(sample_r[link.readSel]); // [R2] [R6]
        end
      end
    end
  end

  // Outputs straight from flip-flops
  assign feChannel      = feChannel_r;
  assign feGain         = feGain_r;
  assign feHold         = feHold_r;
  assign link.eocFlag   = eoc_r;
  assign link.waitDone  = waitDone_r;
  assign link.readValid = readValid_r;
  assign link.readData  = readData_r;

endmodule

// *** hdl/dmc_host_end.sv ***
// Processor-side end: runs one single measurement on request
`timescale 1ns/1ps
module dmc_host_end #(
  parameter int SETTLE_NS = dmc_pkg::MUX_SETTLE_NS
) (
  // Clock and reset
  input  wire  logic               clk,
  input  wire  logic               resetn,
  // Link to the device
  dmc_link_if.host                 link,
  // Measurement requests
  input  wire  logic               measReq,
  input  wire  logic [4:0]         measChannel,
  input  wire  logic [1:0]         measGain,
  input  wire  logic               measWide,
  output logic                     measBusy,
  output logic                     measDone,
  output logic [dmc_pkg::WORD_W-1:0] measData
);
  import dmc_pkg::*;

  localparam int SETTLE_CYCLES = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum {HS_IDLE, HS_SETTLE, HS_START, HS_WAIT, HS_READ, HS_FETCH} dmc_hstate_t;

  dmc_hstate_t       state_r;
  logic              side_r;
  logic              wide_r;
  logic [CNT_W-1:0]  cnt_r;
  logic [1:0]        muxWrite_r;
  logic [WORD_W-1:0] cmdWord_r;
  logic              startReq_r;
  logic              waitReq_r;
  logic              readReq_r;
  logic              measBusy_r;
  logic              measDone_r;
  logic [WORD_W-1:0] measData_r;

  // Measurement sequence
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_r    <= HS_IDLE;
      side_r     <= 1'b0;
      wide_r     <= 1'b0;
      cnt_r      <= '0;
      muxWrite_r <= '0;
      cmdWord_r  <= '0;
      startReq_r <= 1'b0;
      waitReq_r  <= 1'b0;
      readReq_r  <= 1'b0;
      measBusy_r <= 1'b0;
      measDone_r <= 1'b0;
      measData_r <= '0;
    end else begin
      muxWrite_r <= '0;
      startReq_r <= 1'b0;
      waitReq_r  <= 1'b0;
      readReq_r  <= 1'b0;
      measDone_r <= 1'b0;
      case (state_r)
        HS_IDLE: begin
          if (measReq) begin // [R1] [R5]
            side_r     <= ~measChannel[0]; // [R17]
            wide_r     <= measWide;
            muxWrite_r <= measChannel[0] ? 2'h1 : 2'h2; // [R3]
            cmdWord_r  <= {27'h0, measGain, dmc_code_of(measChannel)}; // [R17] [R7]
            cnt_r      <= CNT_W'(SETTLE_CYCLES);
            measBusy_r <= 1'b1;
            state_r    <= HS_SETTLE;
          end
        end
        HS_SETTLE: begin
          if (cnt_r == '0) begin // [R11]
            startReq_r <= 1'b1;
            cmdWord_r  <= side_r ? 32'h0000_0002 : 32'h0000_0001; // [R15]
            state_r    <= HS_START;
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        HS_START: begin
          waitReq_r <= 1'b1; // [R3]
          state_r   <= HS_WAIT;
        end
        HS_WAIT: begin
          if (link.waitDone) begin // [R18]
            readReq_r <= 1'b1;
            state_r   <= HS_READ;
          end
        end
        HS_READ: begin
          state_r <= HS_FETCH;
        end
        HS_FETCH: begin
          if (link.readValid) begin // [R3]
            measData_r <= link.readData;
            measDone_r <= 1'b1;
            measBusy_r <= 1'b0;
            state_r    <= HS_IDLE;
          end
        end
        default: begin
          state_r <= HS_IDLE;
        end
      endcase
    end
  end

  // Outputs straight from flip-flops
  assign link.muxWrite = muxWrite_r;
  assign link.cmdWord  = cmdWord_r;
  assign link.startReq = startReq_r;
  assign link.waitReq  = waitReq_r;
  assign link.readReq  = readReq_r;
  assign link.readSel  = side_r;
  assign link.readWide = wide_r;
  assign measBusy      = measBusy_r;
  assign measDone      = measDone_r;
  assign measData      = measData_r;

endmodule

// *** hdl/dmc_link_if.sv ***
// Link between the processor-side host end and the converter control end
`timescale 1ns/1ps
interface dmc_link_if;
  import dmc_pkg::*;

  // Host commands
  logic [1:0]        muxWrite;
  logic [WORD_W-1:0] cmdWord;
  logic              startReq;
  logic              waitReq;
  logic              readReq;
  logic              readSel;
  logic              readWide;
  // Device answers
  logic [1:0]        eocFlag;
  logic              waitDone;
  logic              readValid;
  logic [WORD_W-1:0] readData;

  modport host (
    output muxWrite, cmdWord, startReq, waitReq, readReq, readSel, readWide,
    input  eocFlag, waitDone, readValid, readData
  );

  modport device (
    input  muxWrite, cmdWord, startReq, waitReq, readReq, readSel, readWide,
    output eocFlag, waitDone, readValid, readData
  );
endinterface

// *** hdl/dmc_pkg.sv ***
// Constants, types and helpers shared by both ends of the converter control link
// What this block does
// [R1] Host addresses single measurements on channels 1 to 16
// [R2] Narrow result is unsigned 0 to 65535
// [R3] Measure: program selector, settle, start, wait, read
// [R4] Wide result: sample in bits 6..23, rest zero
// [R5] Host requests only existing channels; else undefined
// [R6] Result read port for each converter, both formats
// [R7] Gain code bits 3..4; upper bits ignored
// [R8] Odd selector: code 0..7 gives channel 1..15
// [R9] Even converter has its own selector and gain
// [R10] Even selector: code 0..7 gives channel 2..16
// [R11] Host starts only after selector settling time
// [R12] Conversion uses gain programmed for its converter
// [R13] Results are offset binary, midscale means zero volts
// [R14] Pattern with both bits starts both together
// [R15] Start bit 0 odd converter, bit 1 even
// [R16] Conversion takes 2 us, then end of conversion
// [R17] Odd channels to odd converter; code (ch-1)/2
// [R18] Wait completes once every selected converter finished
package dmc_pkg;

  // Clock and timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int CONV_TIME_NS  = 2000;
  localparam int CONV_CYCLES   = CONV_TIME_NS / CLK_PERIOD_NS;
  localparam int MUX_SETTLE_NS = 2000;
  localparam int CNT_W         = 16;

  // Converters
  localparam int N_CONV    = 2;
  localparam int CONV_ODD  = 0;
  localparam int CONV_EVEN = 1;

  // Selector control word fields
  localparam int WORD_W   = 32;
  localparam int CODE_LSB = 0;
  localparam int CODE_MSB = 2;
  localparam int GAIN_LSB = 3;
  localparam int GAIN_MSB = 4;

  // Gain codes
  localparam logic [1:0] GAIN_X1 = 2'h0;
  localparam logic [1:0] GAIN_X2 = 2'h1;
  localparam logic [1:0] GAIN_X4 = 2'h2;
  localparam logic [1:0] GAIN_X8 = 2'h3;

  // Channels and results
  localparam int SAMPLE_W = 18;
  localparam int WIDE_LSB = 6;
  localparam int NARROW_W = 16;
  localparam logic [4:0]  CH_MIN = 5'h01;
  localparam logic [4:0]  CH_MAX = 5'h10;
  localparam logic [31:0] MIDSCALE_NARROW = 32'h0000_8000;
  localparam logic [31:0] MIDSCALE_WIDE   = 32'h0080_0000;

  typedef logic [SAMPLE_W-1:0] dmc_sample_t;

  // Channel number driven by a selector code
  function automatic logic [4:0] dmc_chan_of(input logic [2:0] code, input logic even);
    dmc_chan_of = {1'b0, code, even} + CH_MIN;
  endfunction

  // Selector code for a channel number
  function automatic logic [2:0] dmc_code_of(input logic [4:0] ch);
    logic [4:0] base;
    base = ch - CH_MIN;
    dmc_code_of = base[3:1];
  endfunction

  // Narrow unsigned word from a sample
  function automatic logic [31:0] dmc_narrow(input dmc_sample_t s);
    dmc_narrow = {16'h0000, s[SAMPLE_W-1 -: NARROW_W]};
  endfunction

  // Wide aligned word from a sample
  function automatic logic [31:0] dmc_wide(input dmc_sample_t s);
    dmc_wide = {8'h00, s, 6'h00};
  endfunction

endpackage

// *** verification/dmc_link_properties.sv ***
// Concurrent checks on the link between the host end and the device end
`timescale 1ns/1ps
module dmc_link_properties (
  // Clock and reset
  input wire logic        clk,
  input wire logic        resetn,
  // Host commands
  input wire logic [1:0]  muxWrite,
  input wire logic [31:0] cmdWord,
  input wire logic        startReq,
  input wire logic        waitReq,
  input wire logic        readReq,
  input wire logic        readWide,
  // Device answers
  input wire logic [1:0]  eocFlag,
  input wire logic        waitDone,
  input wire logic        readValid,
  input wire logic [31:0] readData
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  logic [1:0] waitMask_r;

  // Mask of the wait in progress
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      waitMask_r <= 2'h0;
    end else if (waitReq) begin
      waitMask_r <= cmdWord[1:0];
    end
  end

  a_odd_conv_time: assert property (startReq && cmdWord[0] && eocFlag[0] |=>
    !eocFlag[0] ##199 !eocFlag[0] ##1 eocFlag[0]) else $error("odd conversion time wrong");
  a_even_conv_time: assert property (startReq && cmdWord[1] && eocFlag[1] |=>
    !eocFlag[1] ##199 !eocFlag[1] ##1 eocFlag[1]) else $error("even conversion time wrong");
  a_one_lane_start: assert property (startReq |-> $onehot(cmdWord[1:0]))
    else $error("single measurement started wrong lanes");
  a_wait_bounded: assert property (waitReq |-> ##[2:203] waitDone)
    else $error("wait never completed");
  a_done_needs_eoc: assert property (waitDone |-> (waitMask_r & ~$past(eocFlag)) == 2'h0)
    else $error("wait completed before end of conversion");
  a_read_answer: assert property (readReq |=> readValid)
    else $error("read not answered next cycle");
  a_wide_layout: assert property (readValid && $past(readWide) |->
    readData[5:0] == 6'h00 && readData[31:24] == 8'h00) else $error("wide word layout wrong");
  a_narrow_layout: assert property (readValid && !$past(readWide) |-> readData[31:16] == 16'h0000)
    else $error("narrow word out of range");
  a_settle_gap: assert property (muxWrite != 2'h0 |=> !startReq [*2])
    else $error("start before selector settled");
  a_start_then_wait: assert property (startReq |-> ##[1:4] waitReq)
    else $error("no wait after start");
  a_done_then_read: assert property (waitDone |-> ##[0:3] readReq)
    else $error("no read after wait");

  c_odd_start: cover property (startReq && cmdWord[0]);
  c_even_start: cover property (startReq && cmdWord[1]);
  c_wide_read: cover property (readValid && $past(readWide));
endmodule

// *** verification/dual_adc_mux_conversion_control_tb.sv ***
// Bench joining host end and device end, measuring every channel
`timescale 1ns/1ps
module dual_adc_mux_conversion_control_tb;
  import dmc_pkg::*;

  logic                   clk;
  logic                   resetn;
  logic                   measReq;
  logic [4:0]             measChannel;
  logic [1:0]             measGain;
  logic                   measWide;
  logic                   measBusy;
  logic                   measDone;
  logic [31:0]            measData;
  logic [N_CONV-1:0][3:0] feChannel;
  logic [N_CONV-1:0][1:0] feGain;
  logic [N_CONV-1:0]      feHold;
  dmc_sample_t            feSample [N_CONV];
  logic                   midscale;
  int                     nErrors;
  int                     checkCount;
  int                     holdCount [N_CONV];

  dmc_link_if link ();
  dmc_host_end #(.SETTLE_NS(20)) dmc_host_end_i (.clk(clk), .resetn(resetn), .link(link),
    .measReq(measReq), .measChannel(measChannel), .measGain(measGain), .measWide(measWide),
    .measBusy(measBusy), .measDone(measDone), .measData(measData));
  dmc_device_end dmc_device_end_i (.clk(clk), .resetn(resetn), .link(link),
    .feChannel(feChannel), .feGain(feGain), .feHold(feHold), .feSample(feSample));
  dmc_link_properties dmc_link_properties_i (.clk(clk), .resetn(resetn),
    .muxWrite(link.muxWrite), .cmdWord(link.cmdWord), .startReq(link.startReq),
    .waitReq(link.waitReq), .readReq(link.readReq), .readWide(link.readWide),
    .eocFlag(link.eocFlag), .waitDone(link.waitDone), .readValid(link.readValid),
    .readData(link.readData));

  // Front end: sample encodes lane, gain and channel
  always_comb begin
    for (int i = 0; i < N_CONV; i++) begin
      feSample[i] = midscale ? 18'h20000 : {1'(i), feGain[i], 11'h2A5, feChannel[i]};
    end
  end

  // Hold pulses seen on each lane
  always @(posedge clk) begin
    for (int i = 0; i < N_CONV; i++) begin
      if (resetn && feHold[i] === 1'b1) begin
        holdCount[i] <= holdCount[i] + 1;
      end
    end
  end

  // Clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin
      nErrors++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    if (nErrors == 0 && checkCount > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Expected result word for a channel, gain and format
  function automatic logic [31:0] expect_word(input logic [4:0] ch, input logic [1:0] g,
                                              input logic w);
    logic [17:0] s;
    s = midscale ? 18'h20000 : {~ch[0], g, 11'h2A5, 4'(ch - 5'h01)};
    expect_word = w ? {8'h00, s, 6'h00} : {16'h0000, s[17:2]};
  endfunction

  // One measurement, with a refused request while busy
  task automatic measure(input logic [4:0] ch, input logic [1:0] g, input logic w);
    int n;
    @(negedge clk);
    measReq = 1'b1;
    measChannel = ch;
    measGain = g;
    measWide = w;
    @(negedge clk);
    measReq = 1'b0;
    check("busy", {31'h0, measBusy}, 32'h1);
    @(negedge clk);
    measReq = 1'b1;
    measGain = ~g;
    @(negedge clk);
    measReq = 1'b0;
    measGain = g;
    n = 0;
    while (measDone !== 1'b1 && n < 1000) begin
      @(negedge clk);
      n++;
    end
    check("done", {31'h0, measDone}, 32'h1);
    check("data", measData, expect_word(ch, g, w));
    check("channel", {28'h0, feChannel[~ch[0]]}, {27'h0, ch - 5'h01});
    check("gain", {30'h0, feGain[~ch[0]]}, {30'h0, g});
    check("eoc", {31'h0, link.eocFlag[~ch[0]]}, 32'h1);
  endtask

  // Main sequence: all channels, all gains, both formats, then midscale
  initial begin
    resetn = 1'b0;
    measReq = 1'b0;
    measChannel = 5'h01;
    measGain = 2'h0;
    measWide = 1'b0;
    midscale = 1'b0;
    nErrors = 0;
    checkCount = 0;
    repeat (6) @(negedge clk);
    resetn = 1'b1;
    for (int c = 1; c <= 16; c++) begin
      measure(5'(c), 2'((c - 1) >> 1), c > 8);
    end
    midscale = 1'b1;
    measure(5'h07, 2'h3, 1'b0);
    check("mid narrow", measData, 32'h0000_8000);
    measure(5'h10, 2'h0, 1'b1);
    check("mid wide", measData, 32'h0080_0000);
    check("hold odd", holdCount[CONV_ODD], 32'h0000_0009);
    check("hold even", holdCount[CONV_EVEN], 32'h0000_0009);
    report_and_stop();
  end

  // Watchdog
  initial begin
    #200000;
    nErrors++;
    report_and_stop();
  end
endmodule
